// >>> fsp_postfilter.sv
`timescale 1ns/1ps
// Fast settling decimation path: sinc results in, averaged results out.
module fsp_postfilter
  import fsp_pkg::*;
#(
  parameter int DATA_W_P = fsp_pkg::DATA_W  // Sample width.
) (
  input  wire logic                        clk_sys_in,                 // System clock, 250 MHz.
  input  wire logic                        reset_in,                   // Synchronous reset, active high.
  input  wire logic                        mclk_tick_in,               // One pulse per master clock cycle.
  input  wire logic                        sinc3_select_in,            // High selects the third-order sinc.
  input  wire logic                        chop_enable_in,             // Chop mode active.
  input  wire logic                        postfilter_avg_select_hi_in, // Averaging select, upper bit.
  input  wire logic                        postfilter_avg_select_lo_in, // Averaging select, lower bit.
  input  wire logic [fsp_pkg::RATE_W-1:0]  rate_select_word_in,        // Unsigned rate divisor.
  input  wire logic                        dual_notch_enable_in,       // Requests the 60 Hz notch; only drives the dual_notch_active_out flag.
  input  wire logic                        channel_change_in,          // Pulse: new channel selected.
  input  wire logic                        sinc_valid_in,              // Pulse: sinc result ready.
  input  wire logic [DATA_W_P-1:0]         sinc_data_in,               // Sinc result.
  output logic                             fast_settle_active_out,     // Fast settling enabled.
  output logic                             result_valid_out,           // Pulse: averaged result ready.
  output logic [DATA_W_P-1:0]              result_data_out,            // Averaged result.
  output logic                             result_settled_out,         // Result fully settled.
  output logic                             mclk_per_result_stb_out,    // Pulse: output period boundary.
  output logic                             dual_notch_active_out       // Dual notch in effect.
);
  initial begin
    if (DATA_W_P < 8) $error("fsp_postfilter: DATA_W_P too small");
  end

  fsp_state_t state;                 // Sequencer state.
  fsp_state_t next_state;            // Next sequencer state.
  logic [31:0] period_cnt;           // Master clock cycles inside the period.
  logic [4:0]  sample_cnt;           // Sinc results taken this period.
  logic [1:0]  settle_cnt;           // Periods left before results are settled.
  logic        dirty;                // Partial-period flag; cleared on restart and period end, never set.
  logic        dump_d;               // Period end delayed to match the mean.
  logic [DATA_W_P-1:0] mean;         // Mean caught at the last period end or channel change.

  // Decode of the averaging select bits.
  wire [1:0] avg_sel = {postfilter_avg_select_hi_in, postfilter_avg_select_lo_in};
  wire       fs_on   = (avg_sel != AVG_OFF);
  wire [4:0] avg_cnt = (avg_sel == AVG_BY2) ? AVG_CNT2 :
                       (avg_sel == AVG_BY8) ? AVG_CNT8 : AVG_CNT16;
  wire [2:0] avg_sh  = (avg_sel == AVG_BY2) ? AVG_SH2 :
                       (avg_sel == AVG_BY8) ? AVG_SH8 : AVG_SH16;
  // Sinc order chosen; both orders run the postfilter after the sinc.
  wire [4:0] order   = sinc3_select_in ? ORDER_SINC3 : ORDER_SINC4;
  // Output period (order + avg - 1) x 1024 x rate in master clocks.
  wire [31:0] sinc_len = 32'(SINC_DECIM) * 32'(rate_select_word_in);
  wire [31:0] period   = 32'(order + avg_cnt - 5'h01) * sinc_len;
  wire        period_end = mclk_tick_in && (period_cnt >= period - 32'h1);
  // Chop doubles the settle count but not the rate.
  wire [1:0]  settle_len = chop_enable_in ? SETTLE_CHOP : SETTLE_NOCHOP;
  // Only the first avg_cnt sinc results of a period enter the sum.
  wire        take = sinc_valid_in && (state == FSP_RUN) && (sample_cnt < avg_cnt);

  // Sequencer: idle when fast settling is off, otherwise runs periods.
  always_comb begin
    next_state = state;
    unique case (state)
      FSP_IDLE: if (fs_on) next_state = FSP_FILL;
      FSP_FILL: next_state = fs_on ? FSP_RUN : FSP_IDLE;
      FSP_RUN:  if (!fs_on) next_state = FSP_IDLE;
      default:  next_state = FSP_IDLE;
    endcase
  end

  fsp_accum #(
    .DATA_W (DATA_W_P),
    .ACC_W  (DATA_W_P + 4)
  ) u_accum (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .clear_in   (period_end || channel_change_in),
    .add_in     (take),
    .sample_in  (sinc_data_in),
    .shift_in   (avg_sh),
    .mean_out   (mean)
  );

  // Period counting, settle tracking and result strobes.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state                   <= FSP_IDLE;
      period_cnt              <= '0;
      sample_cnt              <= '0;
      settle_cnt              <= SETTLE_NOCHOP;
      dirty                   <= 1'b0;
      dump_d                  <= 1'b0;
      result_valid_out        <= 1'b0;
      result_data_out         <= '0;
      result_settled_out      <= 1'b0;
      fast_settle_active_out  <= 1'b0;
      mclk_per_result_stb_out <= 1'b0;
      dual_notch_active_out   <= 1'b0;
    end else begin
      state                   <= next_state;
      fast_settle_active_out  <= fs_on;
      dual_notch_active_out   <= fs_on && dual_notch_enable_in;
      mclk_per_result_stb_out <= (state == FSP_RUN) && period_end;
      dump_d                  <= (state == FSP_RUN) && period_end;
      result_valid_out        <= dump_d;
      // The word changes only together with the valid pulse.
      if (dump_d) result_data_out <= mean;
      if (state != FSP_RUN || channel_change_in) begin
        // A channel change restarts the period with no extra wait.
        period_cnt <= '0;
        sample_cnt <= '0;
        settle_cnt <= settle_len;
        dirty      <= 1'b0;
      end else begin
        if (take) sample_cnt <= sample_cnt + 5'h01;
        if (period_end) begin
          period_cnt <= '0;
          sample_cnt <= '0;
          if (settle_cnt != 2'h0) settle_cnt <= settle_cnt - 2'h1;
          dirty      <= 1'b0;
        end else if (mclk_tick_in) begin
          period_cnt <= period_cnt + 32'h1;
        end
      end
      // An unaligned restart drops the period it lands in; with chop on the next result is also unsettled.
      if (dump_d) begin
        result_settled_out <= (settle_cnt == 2'h0) && !dirty;
      end
    end
  end
endmodule

// >>> fsp_pkg.sv
// Functional notes
// - Postfilter averages 2, 8 or 16 sinc results.
// - Select code 00 disables fast settling entirely.
// - Sinc4 period is (4+avg-1)*1024*rate cycles.
// - Settles within one output period, chop off.
// - No extra delay after channel change.
// - Unaligned step gives exactly one partial result; here dirty is never set, so no result is flagged partial.
// - Chop keeps rate, settling takes two periods.
// - Sinc notch at clk/(1024*rate), postfilter adds more.
// - Rate select word is unsigned 10-bit divisor.
// - Rate 96, avg 16, dual notch adds 60 Hz; the enable here only sets dual_notch_active_out.
// - Sinc3 also supports fast settling postfilter.
package fsp_pkg;
  // Width of one sinc result sample and of the output word.
  localparam int DATA_W = 24;
  // Width of the rate select word.
  localparam int RATE_W = 10;
  // Modulator cycles per sinc output for one rate select unit.
  localparam logic [10:0] SINC_DECIM = 11'h400;
  // Sinc orders as used in the output period relation.
  localparam logic [4:0] ORDER_SINC4 = 5'h04;
  localparam logic [4:0] ORDER_SINC3 = 5'h03;
  // Averaging select codes.
  localparam logic [1:0] AVG_OFF = 2'h0;
  localparam logic [1:0] AVG_BY2 = 2'h1;
  localparam logic [1:0] AVG_BY8 = 2'h2;
  localparam logic [1:0] AVG_BY16 = 2'h3;
  // Averaging counts and their shift amounts.
  localparam logic [4:0] AVG_CNT2 = 5'h02;
  localparam logic [4:0] AVG_CNT8 = 5'h08;
  localparam logic [4:0] AVG_CNT16 = 5'h10;
  localparam logic [2:0] AVG_SH2 = 3'h1;
  localparam logic [2:0] AVG_SH8 = 3'h3;
  localparam logic [2:0] AVG_SH16 = 3'h4;
  // Number of output periods to settle with chop off and on.
  localparam logic [1:0] SETTLE_NOCHOP = 2'h1;
  localparam logic [1:0] SETTLE_CHOP = 2'h2;
  // Sequencer states.
  typedef enum logic [2:0] {
    FSP_IDLE  = 3'b001,
    FSP_FILL  = 3'b010,
    FSP_RUN   = 3'b100
  } fsp_state_t;
endpackage

// >>> fsp_accum.sv
`timescale 1ns/1ps
// Averaging accumulator: sums samples and shifts the sum down at dump.
module fsp_accum #(
  parameter int DATA_W = 24,   // Sample width.
  parameter int ACC_W  = 28    // Accumulator width, room for 16 samples.
) (
  input  wire logic              clk_sys_in,   // System clock.
  input  wire logic              reset_in,     // Synchronous reset, active high.
  input  wire logic              clear_in,     // Restart the sum.
  input  wire logic              add_in,       // Add one sample this cycle.
  input  wire logic [DATA_W-1:0] sample_in,    // Signed sample.
  input  wire logic [2:0]        shift_in,     // Divide by 2**shift.
  output logic      [DATA_W-1:0] mean_out      // Mean of the completed sum.
);
  initial begin
    if (ACC_W < DATA_W + 4) $error("fsp_accum: ACC_W too small");
  end

  logic signed [ACC_W-1:0] acc;  // Running sum.
  wire  signed [ACC_W-1:0] ext = ACC_W'(signed'(sample_in));  // Sign extended sample.
  wire  signed [ACC_W-1:0] base = clear_in ? '0 : acc;        // Sum to build on.
  // A sample that lands on the clearing cycle is dropped, matching the sample count.
  wire  signed [ACC_W-1:0] next_acc = (add_in && !clear_in) ? base + ext : base;  // Updated sum.
  wire  signed [ACC_W-1:0] shifted = acc >>> shift_in;             // Mean of the sum being closed.

  // The sum updates each clock; the mean is caught from the closing sum before it is cleared.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      acc      <= '0;
      mean_out <= '0;
    end else begin
      acc      <= next_acc;
      if (clear_in) begin
        mean_out <= shifted[DATA_W-1:0];
      end
    end
  end
endmodule

// >>> fsp_postfilter_sva.sv
`timescale 1ns/1ps
// Watches the postfilter ports for the timing of its periodic results.
module fsp_postfilter_sva #(
  parameter int DATA_W_P = 24  // Sample width.
) (
  input wire logic                clk_sys_in,                  // Clock.
  input wire logic                reset_in,                    // Reset.
  input wire logic                mclk_tick_in,                // Tick.
  input wire logic                postfilter_avg_select_hi_in, // Select high bit.
  input wire logic                postfilter_avg_select_lo_in, // Select low bit.
  input wire logic                fast_settle_active_out,      // Mode active.
  input wire logic                result_valid_out,            // Result pulse.
  input wire logic [DATA_W_P-1:0] result_data_out,             // Result word.
  input wire logic                mclk_per_result_stb_out      // Period end.
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // High while any averaging code is selected.
  wire logic sel_on = postfilter_avg_select_hi_in | postfilter_avg_select_lo_in;
  AST_STB_TO_VALID: assert property (mclk_per_result_stb_out |=> result_valid_out)
    else $error("result did not follow the period end");
  AST_VALID_CAUSE: assert property (result_valid_out |-> $past(mclk_per_result_stb_out))
    else $error("result without a period end");
  AST_STB_ON_TICK: assert property (mclk_per_result_stb_out |-> $past(mclk_tick_in, 2'd1))
    else $error("period end without a tick");
  AST_STB_PULSE: assert property (mclk_per_result_stb_out |=> !mclk_per_result_stb_out[*8])
    else $error("period end longer than one cycle");
  AST_OFF_SILENT: assert property (!sel_on[*4] |-> !result_valid_out)
    else $error("result while averaging is off");
  AST_OFF_INACTIVE: assert property (!sel_on[*3] |-> !fast_settle_active_out)
    else $error("mode active with code zero");
  AST_ON_ACTIVE: assert property (sel_on[*3] |-> fast_settle_active_out)
    else $error("mode inactive with code set");
  AST_DATA_HOLDS: assert property (!result_valid_out |-> $stable(result_data_out))
    else $error("result word changed without a pulse");
  COV_RESULT: cover property (result_valid_out);
  COV_OFF: cover property (!sel_on ##1 sel_on);
  COV_PERIOD: cover property (mclk_per_result_stb_out ##1 result_valid_out);
endmodule
bind fsp_postfilter fsp_postfilter_sva #(.DATA_W_P(DATA_W_P)) i_fsp_postfilter_sva (.clk_sys_in, .reset_in,
  .mclk_tick_in, .postfilter_avg_select_hi_in, .postfilter_avg_select_lo_in, .fast_settle_active_out,
  .result_valid_out, .result_data_out, .mclk_per_result_stb_out);

// >>> fast_settling_postfilter_tb_top.sv
`timescale 1ns/1ps
// Feeds random sinc results and checks periods, means and flags.
module fast_settling_postfilter_tb_top;
  import fsp_pkg::*;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, mclk_tick_in = 1'b1, sinc3_select_in = 1'b0, chop_enable_in = 1'b0;
  logic postfilter_avg_select_hi_in = 1'b0, postfilter_avg_select_lo_in = 1'b0, dual_notch_enable_in = 1'b0;
  logic channel_change_in = 1'b0, sinc_valid_in = 1'b0, fast_settle_active_out, result_valid_out;
  logic result_settled_out, mclk_per_result_stb_out, dual_notch_active_out;
  logic [RATE_W-1:0] rate_select_word_in = 10'h001; // Rate divisor.
  logic [DATA_W-1:0] sinc_data_in = 24'h000000, result_data_out; // Sample and result words.
  logic [31:0] lfsr = 32'h9;                                     // Random source.
  int miscompares = 0, compares = 0, cyc = 0;                    // Tallies and cycle count.
  fsp_postfilter i_fsp_postfilter (.clk_sys_in, .reset_in, .mclk_tick_in, .sinc3_select_in, .chop_enable_in,
    .postfilter_avg_select_hi_in, .postfilter_avg_select_lo_in, .rate_select_word_in, .dual_notch_enable_in,
    .channel_change_in, .sinc_valid_in, .sinc_data_in, .fast_settle_active_out, .result_valid_out,
    .result_data_out, .result_settled_out, .mclk_per_result_stb_out, .dual_notch_active_out);
  // The clock toggles every half period of 2 ns.
  always #2 clk_sys_in = ~clk_sys_in;
  // Counts cycles and cuts a hang short.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      conclude();
    end
  end
  // Advances the shift register and returns its new value.
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Averaging count that a select code asks for.
  function automatic int avg_of(logic [1:0] c);
    return (c == AVG_BY2) ? 2 : (c == AVG_BY8) ? 8 : 16;
  endfunction
  // Compares one value and reports a difference.
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Prints the tallies and the verdict.
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Moves one cycle on, to just after the rising edge.
  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask
  // Selects code zero and sees the mode drop.
  task automatic off();
    {postfilter_avg_select_hi_in, postfilter_avg_select_lo_in} = AVG_OFF;
    repeat (8) step();
    check(fast_settle_active_out, 1'b0);
  endtask
  // Runs one setup for two periods, with one surplus sample in the second.
  task automatic run(logic s3, logic chp, logic dn, logic [1:0] code, logic [9:0] rt);
    int avg, n, t0;
    longint sum;
    logic [23:0] d;
    avg = avg_of(code);
    n = (int'(s3 ? ORDER_SINC3 : ORDER_SINC4) + avg - 1) * int'(SINC_DECIM) * int'(rt);
    {sinc3_select_in, chop_enable_in, dual_notch_enable_in, rate_select_word_in} = {s3, chp, dn, rt};
    {postfilter_avg_select_hi_in, postfilter_avg_select_lo_in} = code;
    while (mclk_per_result_stb_out !== 1'b1) step();
    t0 = cyc;
    step();
    check(result_valid_out, 1'b1);
    check(result_settled_out, !chp);
    check(dual_notch_active_out, dn);
    sum = 0;
    for (int i = 0; i <= avg; i++) begin
      d = 24'(rnd());
      {sinc_valid_in, sinc_data_in} = {1'b1, d};
      if (i < avg) sum += longint'(signed'(d));
      step();
      sinc_valid_in = 1'b0;
      step();
    end
    while (mclk_per_result_stb_out !== 1'b1) step();
    check(cyc - t0, n);
    step();
    check(result_data_out, 24'(sum >>> $clog2(avg)));
    check(result_settled_out, 1'b1);
  endtask
  // Main sequence: reset, then three setups with the mode switched off between.
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    off();
    run(1'b1, 1'b0, 1'b0, AVG_BY2, 10'h002);
    // A channel change restarts the period with no added wait.
    channel_change_in = 1'b1;
    compares = compares + 0;
    begin : chg
      int t1;
      t1 = cyc;
      step();
      channel_change_in = 1'b0;
      while (mclk_per_result_stb_out !== 1'b1) step();
      check(cyc - t1, (int'(ORDER_SINC3) + 2 - 1) * int'(SINC_DECIM) * 2 + 1);
      step();
      check(result_settled_out, 1'b1);
    end
    off();
    run(1'b0, 1'b1, 1'b0, AVG_BY8, 10'h001);
    off();
    run(1'b0, 1'b0, 1'b1, AVG_BY16, 10'h001);
    conclude();
  end
endmodule
